/* File: verilog/cwdrw_pkg.sv */
// constants and types for the configuration word decoder and regulator wake logic
package cwdrw_pkg;
  localparam int CLK_MHZ = 100;
  localparam int REG_ON_US = 10;
  localparam int REG_ON_CYC = REG_ON_US * CLK_MHZ;
  localparam int WAKE_LEGACY_US = 190;
  localparam int POWER_UP_TIMER_MS = 64;
  localparam int DLY_W = 23;
  localparam int WORD_W = 24;
  localparam int PAGE_W = 6;
  localparam logic [WORD_W-1:0] CW_UNPROG = 24'hffffff;
  localparam logic [WORD_W-1:0] CW3_UNIMPL = 24'hff10c0;
  localparam logic [WORD_W-1:0] CW4_UNIMPL = 24'hffff00;
  localparam logic [7:0] ID_UPPER = 8'hff;
  localparam logic [19:0] REV_UPPER = 20'h00000;
  localparam logic [WORD_W-1:0] FL_CW2_ADDR = 24'h00abfc;
  localparam logic [WORD_W-1:0] FL_CW3_ADDR = 24'h00abfa;
  localparam logic [WORD_W-1:0] FL_CW4_ADDR = 24'h00abf8;
  localparam logic [WORD_W-1:0] TBL_CW3 = 24'hf80004;
  localparam logic [WORD_W-1:0] TBL_CW4 = 24'hf80006;
  localparam logic [WORD_W-1:0] TBL_ID = 24'hf80008;
  localparam logic [WORD_W-1:0] TBL_REV = 24'hf8000a;
  localparam logic [1:0] MI_CW3 = 2'h0;
  localparam logic [1:0] MI_CW4 = 2'h1;
  localparam logic [1:0] MI_ID = 2'h2;
  localparam logic [1:0] MI_REV = 2'h3;
  localparam int CW2_ONEWAY_BIT = 4;
  localparam int CW3_END_BIT = 15;
  localparam int CW3_CFG_BIT = 14;
  localparam int CW3_DIS_BIT = 13;
  localparam int CW3_WUT_LSB = 10;
  localparam int CW3_PAGE_LSB = 0;
  localparam int CW4_EN_BIT = 7;
  localparam int CW4_BOR_BIT = 6;
  localparam int CW4_RTC_BIT = 5;
  localparam int CW4_OSC_BIT = 4;
  localparam int CW4_PS_LSB = 0;
  localparam logic [1:0] WUT_FAST = 2'h1;
  localparam logic [1:0] WUT_LEGACY = 2'h3;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 6'h3f;
  localparam int DSW_PRE = 32;
  localparam int DSW_PRE_W = 5;
  localparam int DSW_POST_W = 32;
  typedef enum logic [2:0] {
    L_RD2 = 3'h0,
    L_RD3 = 3'h1,
    L_RD4 = 3'h3,
    L_IDS = 3'h2,
    L_REV = 3'h6,
    L_DONE = 3'h7
  } cwdrw_ld_t;
endpackage : cwdrw_pkg

/* File: verilog/cwdrw_cfg_mem.sv */
// four-word store of the table-readable configuration and identity words
`timescale 1ns/10ps
module cwdrw_cfg_mem
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [cwdrw_pkg::WORD_W-1:0] wdata,
  input wire logic re,
  input wire logic rmiss,
  input wire logic [1:0] raddr,
  output logic [cwdrw_pkg::WORD_W-1:0] rdata
);
  import cwdrw_pkg::*;
  logic [WORD_W-1:0] mem [0:3];

  always_ff @(posedge ref_clk)
    if (ce && we)
      mem[waddr] <= wdata;

  // unmapped addresses read as unprogrammed cells
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      rdata <= '0;
    else if (ce && re)
      rdata <= rmiss ? CW_UNPROG : mem[raddr];
endmodule : cwdrw_cfg_mem

/* File: verilog/cwdrw_delay.sv */
// countdown that holds busy for exactly the loaded number of cycles
`timescale 1ns/10ps
module cwdrw_delay
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [cwdrw_pkg::DLY_W-1:0] load,
  output logic busy
);
  import cwdrw_pkg::*;
  logic [DLY_W-1:0] cnt_reg;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      cnt_reg <= '0;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      if (start)
      begin
        cnt_reg <= load - DLY_W'(1);
        busy <= (load != '0);
      end
      else if (busy)
      begin
        cnt_reg <= cnt_reg - DLY_W'(1);
        busy <= (cnt_reg != '0);
      end
    end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !ce);
  start_busy_a: assert property (start && load != '0 |=> busy)
    else $error("delay did not start");
  end_count_a: assert property ($fell(busy) |-> $past(cnt_reg) == '0)
    else $error("delay ended early");
endmodule : cwdrw_delay

/* File: verilog/cwdrw_top.sv */
// configuration word loader, decoder and regulator wake/brown-out control
// Contract
// - with one-way lock off, pin lock may be set and cleared after unlock
// - end select 1 protects page zero to boundary; 0 boundary to last page
// - config page protect 0 protects last page and configuration words
// - wake select 11 gives 190 us legacy start, 01 gives 10 us
// - deep-sleep watchdog enable bit 7 of word four turns watchdog on
// - deep-sleep brown-out enable keeps brown-out alive in deep sleep only
// - calendar clock select 1 picks secondary oscillator, 0 low-power RC
// - deep-sleep watchdog clock select 1 picks low-power RC, 0 secondary
// - deep-sleep watchdog prescaler divides reference clock by 32
// - postscale code c divides by two to the power 2c plus 1
// - identifier word read-only, family code high byte, part code low
// - revision word read-only, 4-bit revision low, bits 23-4 zero
// - enabled regulator holds off execution about 10 us after power-down
// - wake delay length follows flash-power-in-sleep bit and wake select
// - regulator disabled adds 64 ms power-up timer after power-on or brown-out (here after sys_rst only; brown-out needs the regulator enabled)
// - regulator disabled sleep wake uses wake delay; flash power bit shortens
// - flash-power-in-sleep resets 0; then sleep puts flash in standby (here only while the regulator is enabled)
// - flash-power-in-sleep 1 keeps flash powered, wake skips the delay
// - supply below full-speed level sets low-voltage flag, regulator on only
// - regulator tracking failure issues brown-out reset and sets flag
// - segment protection active only when segment protect disable is 0
// - every device reset reloads all configuration from flash words
// - configuration bits read 0 programmed, 1 unprogrammed, via table reads
`timescale 1ns/10ps
module cwdrw_top #(
  parameter int WAKE_LEGACY_CYC = cwdrw_pkg::WAKE_LEGACY_US * cwdrw_pkg::CLK_MHZ,
  parameter int POWER_UP_TIMER_CYC = cwdrw_pkg::POWER_UP_TIMER_MS * 1000 * cwdrw_pkg::CLK_MHZ,
  parameter logic [7:0] FAMILY_CODE = 8'h5a,
  parameter logic [7:0] PART_CODE = 8'h3c,
  parameter logic [3:0] REVISION_NUMBER = 4'h1
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic dev_rst_req,
  output logic fl_rd_req,
  output logic [cwdrw_pkg::WORD_W-1:0] fl_addr,
  input wire logic [cwdrw_pkg::WORD_W-1:0] fl_rd_data,
  input wire logic fl_rd_ack,
  input wire logic tbl_rd,
  input wire logic [cwdrw_pkg::WORD_W-1:0] tbl_addr,
  output logic [cwdrw_pkg::WORD_W-1:0] tbl_rd_data,
  output logic tbl_rd_valid,
  input wire logic unlock_done,
  input wire logic lock_set_req,
  input wire logic lock_clr_req,
  output logic pin_map_lock,
  input wire logic reg_disable_pin,
  input wire logic vdd_below_full_pin,
  input wire logic track_fail_pin,
  input wire logic dsw_ref_pin,
  input wire logic sleep_enter,
  input wire logic wake_evt,
  input wire logic deep_sleep,
  input wire logic dsw_clr,
  input wire logic flash_power_in_sleep_wr,
  input wire logic flash_power_in_sleep_wdata,
  output logic flash_power_in_sleep,
  output logic exec_hold,
  output logic flash_standby,
  output logic low_voltage_flag_set,
  output logic brownout_reset,
  input wire logic brownout_flag_clr,
  output logic brownout_flag,
  output logic seg_protect_en,
  output logic [cwdrw_pkg::PAGE_W-1:0] seg_lower_page,
  output logic [cwdrw_pkg::PAGE_W-1:0] seg_upper_page,
  output logic last_page_protect,
  output logic deep_sleep_wdog_enable,
  output logic deep_sleep_brownout_enable,
  output logic calendar_clock_select,
  output logic deep_sleep_wdog_clock_select,
  output logic dsw_timeout
);
  import cwdrw_pkg::*;

  function automatic logic [2:0] tbl_index(input logic [WORD_W-1:0] a);
    case (a)
      TBL_CW3: tbl_index = {1'b1, MI_CW3};
      TBL_CW4: tbl_index = {1'b1, MI_CW4};
      TBL_ID: tbl_index = {1'b1, MI_ID};
      TBL_REV: tbl_index = {1'b1, MI_REV};
      default: tbl_index = 3'h0;
    endcase
  endfunction : tbl_index

  function automatic logic [DSW_POST_W-1:0] dsw_limit(input logic [3:0] code);
    dsw_limit = (32'h1 << {code, 1'b1}) - 32'h1;
  endfunction : dsw_limit

  cwdrw_ld_t ld_state, ld_next;
  logic [3:0] pin_meta, pin_s, pin_d;
  logic reg_en, ack_ok, reload, bor_evt, boot_go, wake_go, tmr_start, tmr_busy;
  logic mem_we, one_way_stage, one_way_reg, in_sleep_reg, por_pend_reg;
  logic [1:0] mem_waddr, wut_reg;
  logic [2:0] tbl_hit;
  logic [WORD_W-1:0] mem_wdata, w3_stage, w4_stage;
  logic [DLY_W-1:0] tmr_load;
  logic [3:0] dsw_ps_reg;
  logic [DSW_PRE_W-1:0] pre_cnt_reg;
  logic [DSW_POST_W-1:0] post_cnt_reg;
  logic dsw_run, dsw_base;

  // pins from outside the clock domain; only pin_s and its delayed copy pin_d feed logic
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      pin_meta <= '0;
      pin_s <= '0;
      pin_d <= '0;
    end
    else if (ce)
    begin
      pin_meta <= {dsw_ref_pin, track_fail_pin, vdd_below_full_pin, reg_disable_pin};
      pin_s <= pin_meta;
      pin_d <= pin_s;
    end

  assign reg_en = !pin_s[0];
  assign bor_evt = ce && reg_en && pin_s[2] && !pin_d[2];
  assign reload = ce && (dev_rst_req || bor_evt);
  assign ack_ok = fl_rd_req && fl_rd_ack;

  always_comb
  begin
    ld_next = ld_state;
    case (ld_state)
      L_RD2: if (ack_ok) ld_next = L_RD3;
      L_RD3: if (ack_ok) ld_next = L_RD4;
      L_RD4: if (ack_ok) ld_next = L_IDS;
      L_IDS: ld_next = L_REV;
      L_REV: ld_next = L_DONE;
      L_DONE: ld_next = L_DONE;
      default: ld_next = L_RD2;
    endcase
    if (reload)
      ld_next = L_RD2;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ld_state <= L_RD2;
      fl_rd_req <= 1'b0;
      fl_addr <= FL_CW2_ADDR;
    end
    else if (ce)
    begin
      ld_state <= ld_next;
      fl_rd_req <= (ld_next == L_RD2) || (ld_next == L_RD3) || (ld_next == L_RD4);
      fl_addr <= (ld_next == L_RD3) ? FL_CW3_ADDR :
                 (ld_next == L_RD4) ? FL_CW4_ADDR : FL_CW2_ADDR;
    end

  // unimplemented bits forced to 1 so they read unprogrammed
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      one_way_stage <= 1'b1;
      w3_stage <= CW_UNPROG;
      w4_stage <= CW_UNPROG;
    end
    else if (ce && ack_ok && !reload)
    begin
      if (ld_state == L_RD2)
        one_way_stage <= fl_rd_data[CW2_ONEWAY_BIT];
      if (ld_state == L_RD3)
        w3_stage <= fl_rd_data | CW3_UNIMPL;
      if (ld_state == L_RD4)
        w4_stage <= fl_rd_data | CW4_UNIMPL;
    end

  always_comb
  begin
    mem_we = 1'b0;
    mem_waddr = MI_CW3;
    mem_wdata = fl_rd_data | CW3_UNIMPL;
    case (ld_state)
      L_RD3: mem_we = ack_ok;
      L_RD4:
      begin
        mem_we = ack_ok;
        mem_waddr = MI_CW4;
        mem_wdata = fl_rd_data | CW4_UNIMPL;
      end
      L_IDS:
      begin
        mem_we = 1'b1;
        mem_waddr = MI_ID;
        mem_wdata = {ID_UPPER, FAMILY_CODE, PART_CODE};
      end
      L_REV:
      begin
        mem_we = 1'b1;
        mem_waddr = MI_REV;
        mem_wdata = {REV_UPPER, REVISION_NUMBER};
      end
      default: mem_we = 1'b0;
    endcase
  end

  assign tbl_hit = tbl_index(tbl_addr);

  // config space is read-only here; table reads are the only way in
  cwdrw_cfg_mem u_mem (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .we(mem_we && !reload),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(tbl_rd),
    .rmiss(!tbl_hit[2]),
    .raddr(tbl_hit[1:0]),
    .rdata(tbl_rd_data)
  );

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      tbl_rd_valid <= 1'b0;
    else if (ce)
      tbl_rd_valid <= tbl_rd;

  // decoded settings only move on the last load step
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      seg_protect_en <= 1'b0;
      seg_lower_page <= '0;
      seg_upper_page <= LAST_PAGE;
      last_page_protect <= 1'b0;
      wut_reg <= WUT_LEGACY;
      deep_sleep_wdog_enable <= 1'b0;
      deep_sleep_brownout_enable <= 1'b0;
      calendar_clock_select <= 1'b0;
      deep_sleep_wdog_clock_select <= 1'b0;
      dsw_ps_reg <= '0;
      one_way_reg <= 1'b1;
    end
    else if (ce && ld_state == L_REV && !reload)
    begin
      seg_protect_en <= !w3_stage[CW3_DIS_BIT];
      seg_lower_page <= w3_stage[CW3_END_BIT] ? '0 : w3_stage[CW3_PAGE_LSB +: PAGE_W];
      seg_upper_page <= w3_stage[CW3_END_BIT] ? w3_stage[CW3_PAGE_LSB +: PAGE_W] : LAST_PAGE;
      last_page_protect <= !w3_stage[CW3_CFG_BIT];
      wut_reg <= w3_stage[CW3_WUT_LSB +: 2];
      deep_sleep_wdog_enable <= w4_stage[CW4_EN_BIT];
      deep_sleep_brownout_enable <= w4_stage[CW4_BOR_BIT];
      calendar_clock_select <= w4_stage[CW4_RTC_BIT];
      deep_sleep_wdog_clock_select <= w4_stage[CW4_OSC_BIT];
      dsw_ps_reg <= w4_stage[CW4_PS_LSB +: 4];
      one_way_reg <= one_way_stage;
    end

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      pin_map_lock <= 1'b0;
    else if (ce)
    begin
      if (dev_rst_req || bor_evt)
        pin_map_lock <= 1'b0;
      else if (unlock_done && lock_set_req)
        pin_map_lock <= 1'b1;
      else if (unlock_done && lock_clr_req && !one_way_reg)
        pin_map_lock <= 1'b0;
    end

  // reserved wake codes fall back to the legacy time
  assign boot_go = ce && ld_state == L_REV && !reload;
  assign wake_go = ce && wake_evt && in_sleep_reg && !reload;
  assign tmr_start = boot_go || (wake_go && !flash_power_in_sleep);
  always_comb
    if (boot_go)
      tmr_load = reg_en ? DLY_W'(REG_ON_CYC) :
                 (por_pend_reg ? DLY_W'(POWER_UP_TIMER_CYC) : DLY_W'(0));
    else
      tmr_load = (wut_reg == WUT_FAST) ? DLY_W'(REG_ON_CYC) :
                 DLY_W'(WAKE_LEGACY_CYC);

  cwdrw_delay u_delay (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(tmr_start),
    .load(tmr_load),
    .busy(tmr_busy)
  );

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      por_pend_reg <= 1'b1;
      in_sleep_reg <= 1'b0;
      flash_power_in_sleep <= 1'b0;
      exec_hold <= 1'b1;
      flash_standby <= 1'b0;
    end
    else if (ce)
    begin
      if (bor_evt)
        por_pend_reg <= 1'b1;
      else if (boot_go)
        por_pend_reg <= 1'b0;
      if (reload || wake_go)
        in_sleep_reg <= 1'b0;
      else if (sleep_enter && ld_state == L_DONE && !tmr_busy)
        in_sleep_reg <= 1'b1;
      if (flash_power_in_sleep_wr)
        flash_power_in_sleep <= flash_power_in_sleep_wdata;
      exec_hold <= ld_state != L_DONE || tmr_start || tmr_busy || in_sleep_reg;
      flash_standby <= in_sleep_reg && !flash_power_in_sleep && reg_en;
    end

  // brown-out flag: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      low_voltage_flag_set <= 1'b0;
      brownout_reset <= 1'b0;
      brownout_flag <= 1'b0;
    end
    else if (ce)
    begin
      low_voltage_flag_set <= reg_en && pin_s[1] && !pin_d[1];
      brownout_reset <= bor_evt;
      if (bor_evt)
        brownout_flag <= 1'b1;
      else if (brownout_flag_clr)
        brownout_flag <= 1'b0;
    end

  assign dsw_run = deep_sleep_wdog_enable && deep_sleep && !dsw_clr;
  assign dsw_base = pin_s[3] && !pin_d[3] && pre_cnt_reg == DSW_PRE_W'(DSW_PRE - 1);

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      pre_cnt_reg <= '0;
      post_cnt_reg <= '0;
      dsw_timeout <= 1'b0;
    end
    else if (ce)
    begin
      dsw_timeout <= dsw_run && dsw_base && post_cnt_reg == dsw_limit(dsw_ps_reg);
      if (!dsw_run)
      begin
        pre_cnt_reg <= '0;
        post_cnt_reg <= '0;
      end
      else if (pin_s[3] && !pin_d[3])
      begin
        pre_cnt_reg <= pre_cnt_reg + DSW_PRE_W'(1);
        if (dsw_base)
          post_cnt_reg <= (post_cnt_reg == dsw_limit(dsw_ps_reg)) ? '0 :
                          post_cnt_reg + DSW_POST_W'(1);
      end
    end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !ce);
  pin_unlock_a: assert property ($fell(pin_map_lock) && !$past(reload) |->
    $past(unlock_done && lock_clr_req && !one_way_reg)) else $error("lock cleared illegally");
  seg_range_a: assert property ($rose(ld_state == L_DONE) && w3_stage[CW3_END_BIT] |->
    seg_lower_page == '0) else $error("segment lower bound wrong");
  cfg_page_a: assert property ($rose(ld_state == L_DONE) |->
    last_page_protect == !w3_stage[CW3_CFG_BIT]) else $error("config page protect wrong");
  wake_fast_a: assert property (tmr_start && !boot_go && wut_reg == WUT_FAST |->
    tmr_load == DLY_W'(REG_ON_CYC)) else $error("fast wake count wrong");
  dsw_enable_a: assert property ($rose(ld_state == L_DONE) |->
    deep_sleep_wdog_enable == w4_stage[CW4_EN_BIT]) else $error("watchdog enable wrong");
  dsw_pre_a: assert property ($changed(post_cnt_reg) && post_cnt_reg != '0 |->
    $past(pre_cnt_reg) == DSW_PRE_W'(DSW_PRE - 1)) else $error("prescale not 32");
  dsw_post_a: assert property ($rose(dsw_timeout) |->
    $past(post_cnt_reg) == dsw_limit(dsw_ps_reg)) else $error("postscale wrong");
  power_up_timer_len_a: assert property (boot_go && !reg_en && por_pend_reg |->
    tmr_load == DLY_W'(POWER_UP_TIMER_CYC) ##1 exec_hold) else $error("power-up timer missing");
  standby_a: assert property (in_sleep_reg && !flash_power_in_sleep && reg_en |=>
    flash_standby) else $error("flash not in standby");
  skip_wake_a: assert property (wake_go && flash_power_in_sleep |-> !tmr_start)
    else $error("wake delay not skipped");
  low_volt_a: assert property ($rose(pin_s[1]) && !reg_en |=> !low_voltage_flag_set)
    else $error("low voltage flag with regulator off");
  bor_flag_a: assert property (bor_evt |=> brownout_reset && brownout_flag)
    else $error("brown-out not recorded");
  reload_a: assert property (dev_rst_req |=> ld_state == L_RD2)
    else $error("reset did not reload");
  static_a: assert property (ld_state != L_REV |=> $stable(seg_protect_en) &&
    $stable(deep_sleep_wdog_enable)) else $error("setting moved between reloads");
  boot_c: cover property ($rose(ld_state == L_DONE));
  wake_c: cover property (wake_go && !flash_power_in_sleep);
  bor_c: cover property (bor_evt);
  dsw_c: cover property (dsw_timeout);
endmodule : cwdrw_top

/* File: tb/cwdrw_top_test.sv */
// self-checking bench for the configuration decoder and regulator wake logic
`timescale 1ns/10ps
module cwdrw_top_test;
  import cwdrw_pkg::*;
  localparam int LEG = 40;
  localparam int PWR = 50;
  localparam logic [7:0] FAM = 8'h5a; // arbitrary
  localparam logic [7:0] PRT = 8'h3c; // arbitrary
  localparam logic [3:0] REVN = 4'h1; // arbitrary
  logic ref_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, dev_rst_req = 1'b0;
  logic fl_rd_req, fl_rd_ack = 1'b0, tbl_rd = 1'b0, tbl_rd_valid;
  logic [23:0] fl_addr, fl_rd_data = 24'h0, tbl_addr = 24'h0, tbl_rd_data;
  logic [23:0] cw2 = 24'hffffff, cw3 = 24'hffffff, cw4 = 24'hffffff;
  logic unlock_done = 1'b0, lock_set_req = 1'b0, lock_clr_req = 1'b0, pin_map_lock;
  logic reg_disable_pin = 1'b0, vdd_below_full_pin = 1'b0, track_fail_pin = 1'b0;
  logic dsw_ref_pin = 1'b0, sleep_enter = 1'b0, wake_evt = 1'b0, deep_sleep = 1'b0;
  logic dsw_clr = 1'b0, flash_power_in_sleep_wr = 1'b0, flash_power_in_sleep_wdata = 1'b0, brownout_flag_clr = 1'b0;
  logic flash_power_in_sleep, exec_hold, flash_standby, low_voltage_flag_set;
  logic brownout_reset, brownout_flag, seg_protect_en, last_page_protect, dsw_timeout;
  logic [5:0] seg_lower_page, seg_upper_page;
  logic deep_sleep_wdog_enable, deep_sleep_brownout_enable;
  logic calendar_clock_select, deep_sleep_wdog_clock_select;
  int num_errors = 0, checks = 0, lv_cnt = 0, bo_cnt = 0, to_cnt = 0;

  cwdrw_top #(.WAKE_LEGACY_CYC(LEG), .POWER_UP_TIMER_CYC(PWR), .FAMILY_CODE(FAM), .PART_CODE(PRT),
    .REVISION_NUMBER(REVN)) i_cwdrw_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
    .dev_rst_req(dev_rst_req), .fl_rd_req(fl_rd_req), .fl_addr(fl_addr),
    .fl_rd_data(fl_rd_data), .fl_rd_ack(fl_rd_ack), .tbl_rd(tbl_rd), .tbl_addr(tbl_addr),
    .tbl_rd_data(tbl_rd_data), .tbl_rd_valid(tbl_rd_valid), .unlock_done(unlock_done),
    .lock_set_req(lock_set_req), .lock_clr_req(lock_clr_req), .pin_map_lock(pin_map_lock),
    .reg_disable_pin(reg_disable_pin), .vdd_below_full_pin(vdd_below_full_pin),
    .track_fail_pin(track_fail_pin), .dsw_ref_pin(dsw_ref_pin), .sleep_enter(sleep_enter),
    .wake_evt(wake_evt), .deep_sleep(deep_sleep), .dsw_clr(dsw_clr), .flash_power_in_sleep_wr(flash_power_in_sleep_wr),
    .flash_power_in_sleep_wdata(flash_power_in_sleep_wdata), .flash_power_in_sleep(flash_power_in_sleep),
    .exec_hold(exec_hold), .flash_standby(flash_standby),
    .low_voltage_flag_set(low_voltage_flag_set), .brownout_reset(brownout_reset),
    .brownout_flag_clr(brownout_flag_clr), .brownout_flag(brownout_flag),
    .seg_protect_en(seg_protect_en), .seg_lower_page(seg_lower_page),
    .seg_upper_page(seg_upper_page), .last_page_protect(last_page_protect),
    .deep_sleep_wdog_enable(deep_sleep_wdog_enable),
    .deep_sleep_brownout_enable(deep_sleep_brownout_enable),
    .calendar_clock_select(calendar_clock_select),
    .deep_sleep_wdog_clock_select(deep_sleep_wdog_clock_select), .dsw_timeout(dsw_timeout));

  always #5 ref_clk = ~ref_clk;

  // flash answers every other cycle; data is scrambled while no ack stands
  always @(negedge ref_clk)
  begin
    if (fl_rd_req === 1'b1 && fl_rd_ack === 1'b0)
    begin
      fl_rd_ack <= 1'b1;
      fl_rd_data <= (fl_addr === FL_CW2_ADDR) ? cw2 : (fl_addr === FL_CW3_ADDR) ? cw3 : cw4;
    end
    else
    begin
      fl_rd_ack <= 1'b0;
      fl_rd_data <= ~fl_rd_data;
    end
  end

  always @(posedge ref_clk)
  begin
    lv_cnt <= lv_cnt + int'(low_voltage_flag_set === 1'b1);
    bo_cnt <= bo_cnt + int'(brownout_reset === 1'b1);
    to_cnt <= to_cnt + int'(dsw_timeout === 1'b1);
  end

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic wait_run();
    int n;
    n = 0;
    while (exec_hold !== 1'b0 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk("boot wait", 24'h0, {23'h0, n >= 3000});
  endtask : wait_run

  task automatic load(input logic [23:0] w2, input logic [23:0] w3, input logic [23:0] w4);
    cw2 = w2;
    cw3 = w3;
    cw4 = w4;
    dev_rst_req = 1'b1;
    cyc(1);
    dev_rst_req = 1'b0;
    cyc(4);
    wait_run();
  endtask : load

  task automatic trd(input logic [23:0] a, input logic [23:0] exp);
    tbl_rd = 1'b1;
    tbl_addr = a;
    cyc(1);
    chk("tbl_rd_valid", 24'h1, {23'h0, tbl_rd_valid});
    chk("tbl_rd_data", exp, tbl_rd_data);
  endtask : trd

  task automatic chk_dec(input logic [23:0] w3, input logic [23:0] w4);
    logic [23:0] exp, got;
    exp = {6'h00, w3[15] ? 6'h00 : w3[5:0], w3[15] ? w3[5:0] : LAST_PAGE, ~w3[13], ~w3[14],
      w4[7:4]};
    got = {6'h00, seg_lower_page, seg_upper_page, seg_protect_en, last_page_protect,
      deep_sleep_wdog_enable, deep_sleep_brownout_enable, calendar_clock_select,
      deep_sleep_wdog_clock_select};
    // page bounds mean nothing while segment protection is off
    if (w3[13])
    begin
      exp[17:6] = 12'h0;
      got[17:6] = 12'h0;
    end
    chk("decoded fields", exp, got);
  endtask : chk_dec

  task automatic pulse_lock(input logic set, input logic unl);
    unlock_done = unl;
    lock_set_req = set;
    lock_clr_req = ~set;
    cyc(1);
    lock_set_req = 1'b0;
    lock_clr_req = 1'b0;
    unlock_done = 1'b0;
  endtask : pulse_lock

  initial
  begin
    // more than three times the expected run, well inside the cycle budget
    #500_000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    int n, exp;
    logic [23:0] w2, w3, w4;
    logic p;
    void'($urandom(26));
    cyc(3);
    sys_rst = 1'b0;
    chk("flash_power_in_sleep", 24'h0, {23'h0, flash_power_in_sleep});
    chk("exec_hold", 24'h1, {23'h0, exec_hold});
    wait_run();
    for (int i = 0; i < 6; i++)
    begin
      w2 = (i == 0) ? 24'hffffff : (i == 1) ? 24'h0 : 24'($urandom());
      w3 = (i == 0) ? 24'hffffff : (i == 1) ? 24'h0 : 24'($urandom());
      w4 = (i == 0) ? 24'hffffff : (i == 1) ? 24'h0 : 24'($urandom());
      if (i == 2)
        w3[11:10] = WUT_FAST;
      p = (i == 1 || i == 3);
      load(w2, w3, w4);
      chk_dec(w3 | CW3_UNIMPL, w4 | CW4_UNIMPL);
      trd(TBL_CW3, w3 | CW3_UNIMPL);
      trd(TBL_CW4, w4 | CW4_UNIMPL);
      trd(TBL_ID, {8'hff, FAM, PRT});
      trd(TBL_REV, {20'h0, REVN});
      trd(24'hf8000c, 24'hffffff);
      tbl_rd = 1'b0;
      pulse_lock(1'b1, 1'b0);
      chk("pin_map_lock", 24'h0, {23'h0, pin_map_lock});
      pulse_lock(1'b1, 1'b1);
      chk("pin_map_lock", 24'h1, {23'h0, pin_map_lock});
      pulse_lock(1'b0, 1'b1);
      chk("pin_map_lock", {23'h0, w2[4]}, {23'h0, pin_map_lock});
      flash_power_in_sleep_wr = 1'b1;
      flash_power_in_sleep_wdata = p;
      cyc(1);
      flash_power_in_sleep_wr = 1'b0;
      chk("flash_power_in_sleep", {23'h0, p}, {23'h0, flash_power_in_sleep});
      sleep_enter = 1'b1;
      cyc(1);
      sleep_enter = 1'b0;
      cyc(2);
      chk("exec_hold", 24'h1, {23'h0, exec_hold});
      chk("flash_standby", {23'h0, ~p}, {23'h0, flash_standby});
      wake_evt = 1'b1;
      cyc(1);
      wake_evt = 1'b0;
      n = 1;
      while (exec_hold !== 1'b0 && n < 3000)
      begin
        cyc(1);
        n++;
      end
      // wake: none with flash powered, else fast or legacy count
      exp = p ? 2 : (((w3[11:10]) == WUT_FAST) ? REG_ON_CYC : LEG) + 2;
      chk("wake length off", 24'h0, {23'h0, n < exp - 2 || n > exp + 2});
    end
    vdd_below_full_pin = 1'b1;
    cyc(8);
    chk("low voltage pulses", 24'h1, 24'(lv_cnt));
    vdd_below_full_pin = 1'b0;
    reg_disable_pin = 1'b1;
    cyc(8);
    vdd_below_full_pin = 1'b1;
    cyc(8);
    chk("low voltage pulses", 24'h1, 24'(lv_cnt));
    vdd_below_full_pin = 1'b0;
    reg_disable_pin = 1'b0;
    cyc(8);
    track_fail_pin = 1'b1;
    cyc(8);
    chk("brownout pulses", 24'h1, 24'(bo_cnt));
    chk("brownout_flag", 24'h1, {23'h0, brownout_flag});
    track_fail_pin = 1'b0;
    brownout_flag_clr = 1'b1;
    cyc(1);
    brownout_flag_clr = 1'b0;
    chk("brownout_flag", 24'h0, {23'h0, brownout_flag});
    wait_run();
    for (int c = 0; c < 2; c++)
    begin
      load(24'hffffff, 24'hffffff, {20'h00008, 4'(c)});
      dsw_clr = 1'b1;
      cyc(2);
      dsw_clr = 1'b0;
      deep_sleep = 1'b1;
      exp = to_cnt;
      n = 0;
      while (to_cnt == exp && n < 300)
      begin
        dsw_ref_pin = 1'b1;
        n++;
        cyc(4);
        dsw_ref_pin = 1'b0;
        cyc(4);
      end
      deep_sleep = 1'b0;
      chk("watchdog edges", 24'(32 * (2 ** (2 * c + 1))), 24'(n));
    end
    // regulator off: power-up timer only after a true reset, not a reload
    reg_disable_pin = 1'b1;
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    n = 0;
    while (exec_hold !== 1'b0 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk("power-up wait off", 24'h0, {23'h0, n < PWR || n > PWR + 20});
    dev_rst_req = 1'b1;
    cyc(1);
    dev_rst_req = 1'b0;
    n = 0;
    while (exec_hold !== 1'b0 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk("reload wait off", 24'h0, {23'h0, n > 20});
    wrap_up();
  end
endmodule : cwdrw_top_test
